// >>> xlat_pkg.sv
// translation table constants, space codes and register map for the outbound translator
// assumes one bridge clock; nothing else shares these names
package xlat_pkg;
    // ==============================================================
    // address space indicator codes
    localparam logic [1:0] SPACE_MEM32 = 2'b00;
    localparam logic [1:0] SPACE_MEM64 = 2'b01;
    localparam logic [1:0] SPACE_IO = 2'b10;
    localparam logic [1:0] SPACE_CFG = 2'b11;
    // ==============================================================
    // entry field positions
    localparam int ENTRY_SPACE_LSB = 0;
    localparam int ENTRY_SPACE_MSB = 1;
    // ==============================================================
    // register map, word addresses on the 32-bit slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_ENTRY_BASE = 8'h80;
    localparam int CTRL_REFUSED_CLR_BIT = 0;
    localparam int STATUS_REFUSED_BIT = 0;
    localparam int STATUS_WIDE_BIT = 1;
    localparam int STATUS_FIXED_BIT = 2;
    localparam logic [31:0] RESET_STATUS = 32'h0000_0000;
    // ==============================================================
    // configuration request type codes in pci address bits 1:0
    localparam logic [1:0] CFG_TYPE0 = 2'b00;
    localparam logic [1:0] CFG_TYPE1 = 2'b01;
    // bus answer states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;
endpackage : xlat_pkg

// >>> xlat_table_mem.sv
// translation table storage: two 32-bit words per entry, two registered read ports (translation and register)
// assumes a single clock; contents are undefined until written
`timescale 1ns/1ps
module xlat_table_mem #(
    parameter int ENTRIES = 16,
    parameter int IDX_W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_we,
    input wire logic [IDX_W:0] i_waddr,
    input wire logic [31:0] i_wdata,
    input wire logic [IDX_W-1:0] i_xidx,
    output logic [63:0] o_xentry,
    input wire logic [IDX_W:0] i_raddr,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [0:2*ENTRIES-1];
    logic [63:0] xentry_ff;
    logic [31:0] rdata_ff;
    // no reset: the table holds nothing valid until software writes it
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        xentry_ff <= {mem[{i_xidx, 1'b1}], mem[{i_xidx, 1'b0}]};
        rdata_ff <= mem[i_raddr];
    end
    assign o_xentry = xentry_ff;
    assign o_rdata = rdata_ff;
endmodule : xlat_table_mem

// >>> pci_outbound_xlat.sv
// outbound translation: interconnect address to pci address, space and command class
// assumes the request holds i_req_addr/i_req_be stable while i_req_valid is high
`timescale 1ns/1ps
module pci_outbound_xlat
    import xlat_pkg::*;
#(
    parameter int TABLE_BITS = 4,
    parameter int PASS_BITS = 20,
    parameter bit WIDE_PATH = 1'b1,
    parameter bit FIXED_TABLE = 1'b0,
    parameter logic [63:0] FIXED_ENTRY = 64'h0000_0000_0000_0000
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [PASS_BITS+TABLE_BITS-1:0] i_req_addr,
    input wire logic [7:0] i_req_be,
    output logic o_req_ready,
    output logic o_xl_valid,
    output logic [63:0] o_xl_addr,
    output logic [1:0] o_xl_space,
    output logic o_xl_dac,
    output logic o_xl_write,
    output logic o_xl_posted,
    input wire logic i_tgt_valid,
    input wire logic i_tgt_write,
    input wire logic i_tgt_is_cfg,
    output logic o_tgt_accept,
    output logic o_tgt_complete_now,
    output logic o_dwc_forward
);
    import xlat_pkg::*;
    localparam int ENTRIES = 1 << TABLE_BITS;
    localparam int AW = PASS_BITS + TABLE_BITS;

    // ==============================================================
    // helpers
    function automatic logic [2:0] first_byte(input logic [7:0] be, input bit wide);
        logic [2:0] r;
        r = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (be[i]) begin
                r = i[2:0];
            end
        end
        if (!wide) begin
            r[2] = 1'b0;
        end
        return r;
    endfunction : first_byte

    function automatic logic [20:0] one_hot_dev(input logic [4:0] dev);
        return 21'h1 << dev;
    endfunction : one_hot_dev

    // ==============================================================
    // register slave
    bus_state_t bus_ff, nxt_bus;
    logic refused_ff, nxt_refused;
    logic [31:0] rdata_ff, nxt_rdata;
    logic tbl_we;
    logic is_entry;
    logic [TABLE_BITS:0] tbl_waddr;
    logic [31:0] mem_rdata;
    logic [63:0] mem_entry;
    logic refuse_wr;

    assign is_entry = i_avs_address[7] == REG_ENTRY_BASE[7];
    assign tbl_waddr = i_avs_address[TABLE_BITS:0];
    // the low word of an entry carries the space code; 01 is barred on a narrow path
    assign refuse_wr = !WIDE_PATH && !tbl_waddr[0]
        && i_avs_writedata[ENTRY_SPACE_MSB:ENTRY_SPACE_LSB] == SPACE_MEM64;
    assign tbl_we = i_avs_write && (bus_ff == BUS_DONE) && is_entry && !FIXED_TABLE
        && !refuse_wr && (&i_avs_byteenable);

    always_comb begin
        nxt_bus = bus_ff;
        nxt_refused = refused_ff;
        nxt_rdata = rdata_ff;
        case (bus_ff)
            BUS_IDLE: begin
                if (i_avs_write) begin
                    nxt_bus = BUS_DONE;
                end else if (i_avs_read) begin
                    nxt_bus = BUS_READ;
                end
            end
            BUS_READ: begin
                nxt_bus = BUS_DONE;
                nxt_rdata = 32'h0;
                if (i_avs_address == REG_STATUS) begin
                    nxt_rdata[STATUS_REFUSED_BIT] = refused_ff;
                    nxt_rdata[STATUS_WIDE_BIT] = WIDE_PATH;
                    nxt_rdata[STATUS_FIXED_BIT] = FIXED_TABLE;
                end else if (is_entry) begin
                    nxt_rdata = FIXED_TABLE ? (tbl_waddr[0] ? FIXED_ENTRY[63:32]
                        : FIXED_ENTRY[31:0]) : mem_rdata;
                end
            end
            BUS_DONE: begin
                nxt_bus = BUS_IDLE;
                // a write lands at the edge that ends its wait; set wins over clear
                if (i_avs_write) begin
                    if (i_avs_address == REG_CTRL && i_avs_writedata[CTRL_REFUSED_CLR_BIT]) begin
                        nxt_refused = 1'b0;
                    end
                    if (is_entry && refuse_wr && !FIXED_TABLE) begin
                        nxt_refused = 1'b1;
                    end
                end
            end
            default: begin
                nxt_bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            bus_ff <= BUS_IDLE;
            refused_ff <= RESET_STATUS[STATUS_REFUSED_BIT];
            rdata_ff <= 32'h0;
        end else begin
            bus_ff <= nxt_bus;
            refused_ff <= nxt_refused;
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && bus_ff != BUS_DONE;
    assign o_avs_readdata = rdata_ff;

    // ==============================================================
    // table storage
    xlat_table_mem #(
        .ENTRIES(ENTRIES),
        .IDX_W(TABLE_BITS)
    ) u_mem (
        .i_clk_sys(i_clk_sys),
        .i_we(tbl_we),
        .i_waddr(tbl_waddr),
        .i_wdata(i_avs_writedata),
        .i_xidx(i_req_addr[AW-1:PASS_BITS]),
        .o_xentry(mem_entry),
        .i_raddr(tbl_waddr),
        .o_rdata(mem_rdata)
    );

    // ==============================================================
    // translation pipe: lookup cycle, then output register
    // entries are trusted as written; no valid bits are kept
    logic look_ff, nxt_look;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [7:0] be_ff, nxt_be;
    logic wr_ff, nxt_wr;
    logic xl_valid_ff, nxt_xl_valid;
    logic [63:0] xl_addr_ff, nxt_xl_addr;
    logic [1:0] xl_space_ff, nxt_xl_space;
    logic xl_dac_ff, nxt_xl_dac;
    logic xl_write_ff, nxt_xl_write;
    logic [63:0] entry;
    logic [63:0] raw;
    logic [2:0] io_low;

    assign entry = FIXED_TABLE ? FIXED_ENTRY : mem_entry;
    assign o_req_ready = !look_ff;

    always_comb begin
        nxt_look = i_req_valid && !look_ff;
        nxt_addr = look_ff ? addr_ff : i_req_addr;
        nxt_be = look_ff ? be_ff : i_req_be;
        nxt_wr = look_ff ? wr_ff : i_req_write;
        nxt_xl_valid = look_ff;
        nxt_xl_addr = xl_addr_ff;
        nxt_xl_space = xl_space_ff;
        nxt_xl_dac = xl_dac_ff;
        nxt_xl_write = xl_write_ff;
        raw = 64'h0;
        io_low = 3'h0;
        if (look_ff) begin
            // high bits from entry, low bits from request
            raw = {entry[63:AW], entry[AW-1:PASS_BITS], addr_ff[PASS_BITS-1:0]};
            nxt_xl_space = entry[ENTRY_SPACE_MSB:ENTRY_SPACE_LSB];
            nxt_xl_write = wr_ff;
            nxt_xl_dac = 1'b0;
            case (entry[ENTRY_SPACE_MSB:ENTRY_SPACE_LSB])
                SPACE_MEM32: begin
                    nxt_xl_addr = {32'h0, raw[31:0]};
                end
                SPACE_MEM64: begin
                    nxt_xl_addr = raw;
                    nxt_xl_dac = 1'b1;
                end
                SPACE_IO: begin
                    io_low = first_byte(be_ff, WIDE_PATH);
                    // narrow path keeps the translated bit 2
                    if (!WIDE_PATH) begin
                        io_low[2] = raw[2];
                    end
                    nxt_xl_addr = {32'h0, raw[31:3], io_low};
                end
                SPACE_CFG: begin
                    if (raw[23:16] == 8'h00) begin
                        nxt_xl_addr = {32'h0, one_hot_dev(raw[15:11]), raw[10:2],
                            CFG_TYPE0};
                    end else begin
                        nxt_xl_addr = {32'h0, raw[31:2], CFG_TYPE1};
                    end
                end
                default: begin
                    nxt_xl_addr = raw;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            look_ff <= 1'b0;
            addr_ff <= '0;
            be_ff <= 8'h0;
            wr_ff <= 1'b0;
            xl_valid_ff <= 1'b0;
            xl_addr_ff <= 64'h0;
            xl_space_ff <= SPACE_MEM32;
            xl_dac_ff <= 1'b0;
            xl_write_ff <= 1'b0;
        end else begin
            look_ff <= nxt_look;
            addr_ff <= nxt_addr;
            be_ff <= nxt_be;
            wr_ff <= nxt_wr;
            xl_valid_ff <= nxt_xl_valid;
            xl_addr_ff <= nxt_xl_addr;
            xl_space_ff <= nxt_xl_space;
            xl_dac_ff <= nxt_xl_dac;
            xl_write_ff <= nxt_xl_write;
        end
    end

    assign o_xl_valid = xl_valid_ff;
    assign o_xl_addr = xl_addr_ff;
    assign o_xl_space = xl_space_ff;
    assign o_xl_dac = xl_dac_ff;
    assign o_xl_write = xl_write_ff;
    // every outbound write is posted, i/o and configuration included
    assign o_xl_posted = xl_write_ff;

    // ==============================================================
    // target side: reads always accepted, writes only for configuration, never delayed
    assign o_tgt_accept = i_tgt_valid && (!i_tgt_write || i_tgt_is_cfg);
    assign o_tgt_complete_now = i_tgt_valid && i_tgt_write && i_tgt_is_cfg;
    assign o_dwc_forward = 1'b0;

    // ==============================================================
    // checks
    xl_pipe_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_req_valid && o_req_ready) |=> ##1 o_xl_valid)
        else $error("translated request missing");
    low_pass_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (look_ff && entry[1] == 1'b0) |=> o_xl_addr[PASS_BITS-1:0]
        == $past(addr_ff[PASS_BITS-1:0]))
        else $error("low address bits altered");
    mem32_hi_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_xl_valid && o_xl_space == SPACE_MEM32) |-> o_xl_addr[63:32] == 32'h0)
        else $error("32-bit address has high bits");
    dac_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_xl_valid |-> (o_xl_dac == (o_xl_space == SPACE_MEM64)))
        else $error("dual address cycle mismatch");
    narrow_ref_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        tbl_we |-> (WIDE_PATH || tbl_waddr[0] || i_avs_writedata[1:0] != SPACE_MEM64))
        else $error("64-bit code stored on narrow path");
    cfg0_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_xl_valid && o_xl_space == SPACE_CFG && o_xl_addr[1:0] == CFG_TYPE0)
        |-> $onehot(o_xl_addr[31:11]))
        else $error("type 0 select not one-hot");
    cfg_type_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_xl_valid && o_xl_space == SPACE_CFG) |-> o_xl_addr[1] == 1'b0)
        else $error("bad configuration type code");
    tgt_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_tgt_valid && i_tgt_write && !i_tgt_is_cfg) |-> !o_tgt_accept)
        else $error("non-configuration target write accepted");
    dwc_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !o_dwc_forward)
        else $error("delayed write completion forwarded");
    bus_ans_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        ($rose(i_avs_read) && bus_ff == BUS_IDLE) |-> ##[1:2] !o_avs_waitrequest)
        else $error("register read not answered");
endmodule : pci_outbound_xlat

// >>> req_master_model.sv
// requester model: holds one translation request until the translator takes it
// assumes the bench keeps i_go high until o_free is seen at an edge
`timescale 1ns/1ps
module req_master_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_go,
    input wire logic i_wr,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_be,
    input wire logic i_ready,
    output logic o_req_valid,
    output logic o_req_write,
    output logic [23:0] o_req_addr,
    output logic [7:0] o_req_be,
    output logic o_free
);
    logic valid_ff, nxt_valid;
    logic [32:0] data_ff, nxt_data;
    // ==============================================================
    // request state
    always_comb begin
        nxt_valid = valid_ff;
        nxt_data = data_ff;
        if (i_go && o_free) begin
            // only programmed entries are aimed at
            nxt_valid = 1'b1;
            nxt_data = {i_wr, i_addr, i_be};
        end else if (valid_ff && i_ready) begin
            // released lines invert so a stale value never looks valid
            nxt_valid = 1'b0;
            nxt_data = ~data_ff;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            valid_ff <= 1'b0;
            data_ff <= 33'h0;
        end else begin
            valid_ff <= nxt_valid;
            data_ff <= nxt_data;
        end
    end
    assign o_free = !valid_ff || i_ready;
    assign o_req_valid = valid_ff;
    assign {o_req_write, o_req_addr, o_req_be} = data_ff;
endmodule : req_master_model

// >>> test_pci_outbound_xlat.sv
// self-checking bench: register port, translation path and target side
// assumes default parameters: 16 entries, 20 pass bits, wide path, dynamic table
// a second, narrow-path instance shares the register bus to check code refusal
`timescale 1ns/1ps
module test_pci_outbound_xlat;
    import xlat_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] av_addr = 8'h00;
    logic av_rd = 1'b0, av_wr = 1'b0, go = 1'b0, gwr = 1'b0;
    logic [31:0] av_wd = 32'h0, av_rdata;
    logic [23:0] gaddr = 24'h0, req_addr;
    logic [7:0] gbe = 8'h00, req_be;
    logic tv = 1'b0, tw = 1'b0, tc = 1'b0;
    logic av_wait, req_valid, req_write, req_ready, free, xl_valid, xl_dac, xl_write;
    logic xl_posted, tgt_acc, tgt_now, dwc;
    logic [63:0] xl_addr;
    logic [1:0] xl_space;
    logic [31:0] n_rdata, nrd;
    logic n_wait;
    int mismatches = 0, tests_run = 0;
    logic [63:0] tbl [16];
    logic [68:0] expq [$];
    always #12.5 i_clk_sys = ~i_clk_sys;
    pci_outbound_xlat pci_outbound_xlat_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(av_wd), .i_avs_byteenable(4'hf), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait), .i_req_valid(req_valid), .i_req_write(req_write),
        .i_req_addr(req_addr), .i_req_be(req_be), .o_req_ready(req_ready),
        .o_xl_valid(xl_valid), .o_xl_addr(xl_addr), .o_xl_space(xl_space), .o_xl_dac(xl_dac),
        .o_xl_write(xl_write), .o_xl_posted(xl_posted), .i_tgt_valid(tv), .i_tgt_write(tw),
        .i_tgt_is_cfg(tc), .o_tgt_accept(tgt_acc), .o_tgt_complete_now(tgt_now),
        .o_dwc_forward(dwc));
    // translation inputs idle: this instance only exercises the register side
    pci_outbound_xlat #(.WIDE_PATH(1'b0)) pci_outbound_xlat_n_i (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(n_rdata), .o_avs_waitrequest(n_wait), .i_req_valid(1'b0),
        .i_req_write(1'b0), .i_req_addr(24'h0), .i_req_be(8'h00), .o_req_ready(),
        .o_xl_valid(), .o_xl_addr(), .o_xl_space(), .o_xl_dac(), .o_xl_write(),
        .o_xl_posted(), .i_tgt_valid(tv), .i_tgt_write(tw), .i_tgt_is_cfg(tc),
        .o_tgt_accept(), .o_tgt_complete_now(), .o_dwc_forward());
    req_master_model req_master_model_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_go(go), .i_wr(gwr), .i_addr(gaddr), .i_be(gbe), .i_ready(req_ready),
        .o_req_valid(req_valid), .o_req_write(req_write), .o_req_addr(req_addr),
        .o_req_be(req_be), .o_free(free));
    // ==============================================================
    // checking and reporting
    task final_report;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input string n, input logic [68:0] e, input logic [68:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // reference translation, worked from the entry and the request alone
    function automatic logic [68:0] exp_xl(logic [63:0] en, logic [23:0] a, logic [7:0] be,
        logic wr);
        logic [63:0] t, e;
        int fb;
        t = {en[63:20], a[19:0]};
        fb = 0;
        while (fb < 7 && !be[fb]) fb++;
        case (en[1:0])
            SPACE_MEM32: e = {32'h0, t[31:0]};
            SPACE_MEM64: e = t;
            SPACE_IO: e = {32'h0, t[31:3], 3'(fb)};
            default: begin
                if (t[23:16] == 8'h00) e = {32'h0, 21'h1 << t[15:11], t[10:2], CFG_TYPE0};
                else e = {32'h0, t[31:2], CFG_TYPE1};
            end
        endcase
        return {e, en[1:0], en[1:0] == SPACE_MEM64, wr, wr};
    endfunction : exp_xl
    // ==============================================================
    // bus cycles: request held until waitrequest is seen low at an edge
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        av_addr <= a;
        av_wd <= d;
        av_wr <= 1'b1;
        do @(posedge i_clk_sys); while (av_wait !== 1'b0);
        av_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask : bus_wr
    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        av_addr <= a;
        av_rd <= 1'b1;
        do @(posedge i_clk_sys); while (av_wait !== 1'b0);
        d = av_rdata;
        nrd = n_rdata;
        check("n_wait", 69'h0, n_wait);
        av_rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask : bus_rd
    // go stays high between calls so back-to-back requests never retoggle it
    task send(input int k, input logic [19:0] lo, input logic [7:0] be, input logic wr);
        go <= 1'b1;
        gaddr <= {4'(k), lo};
        gbe <= be;
        gwr <= wr;
        do @(posedge i_clk_sys); while (free !== 1'b1);
        expq.push_back(exp_xl(tbl[k], {4'(k), lo}, be, wr));
    endtask : send
    always @(posedge i_clk_sys) begin
        if (xl_valid === 1'b1) begin
            if (expq.size() == 0) check("xl_extra", 69'h0, 69'h1);
            else check("xl", expq.pop_front(),
                {xl_addr, xl_space, xl_dac, xl_write, xl_posted});
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        mismatches++;
        final_report;
    end
    // ==============================================================
    // main sequence
    initial begin
        logic [31:0] rd;
        logic [19:0] lo;
        logic [7:0] be;
        int k;
        void'($urandom(32021));
        repeat (3) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        check("reset", 69'h1, {av_rdata, xl_valid, req_ready});
        bus_rd(REG_STATUS, rd);
        check("status", 69'(32'h1 << STATUS_WIDE_BIT), rd);
        check("n_status", 69'h0, nrd);
        bus_rd(8'h40, rd);
        check("unmapped", 69'h0, rd);
        for (k = 0; k < 16; k++) begin
            tbl[k] = {$urandom(), $urandom()};
            tbl[k][1:0] = 2'(k);
            if (k == 3 || k == 11) tbl[k][23:20] = 4'h0;
            bus_wr(REG_ENTRY_BASE + 8'(2 * k), tbl[k][31:0]);
            bus_wr(REG_ENTRY_BASE + 8'(2 * k + 1), tbl[k][63:32]);
        end
        bus_rd(REG_STATUS, rd);
        check("refused", 69'h1, nrd);
        check("wide_status", 69'(32'h1 << STATUS_WIDE_BIT), rd);
        bus_wr(REG_CTRL, 32'h1 << CTRL_REFUSED_CLR_BIT);
        bus_rd(REG_STATUS, rd);
        check("cleared", 69'h0, nrd);
        for (k = 0; k < 32; k++) begin
            bus_rd(REG_ENTRY_BASE + 8'(k), rd);
            check("entry", tbl[k / 2][32 * (k % 2) +: 32], rd);
            if (k % 8 != 2) check("n_entry", tbl[k / 2][32 * (k % 2) +: 32], nrd);
        end
        for (int n = 0; n < 96; n++) begin
            k = $urandom % 16;
            lo = 20'($urandom);
            if (tbl[k][1:0] == SPACE_CFG) begin
                lo[15:11] = 5'($urandom % 21);
                if ($urandom % 2) lo[19:16] = 4'h0;
            end
            be = 8'($urandom);
            if (be == 8'h00) be = 8'h01;
            send(k, lo, be, 1'($urandom));
            if (gwr && tbl[k][1]) send(k, lo, be, 1'b0);
        end
        send(2, 20'hfffff, 8'h80, 1'b1);
        send(3, 20'h0a000, 8'h01, 1'b1);
        go <= 1'b0;
        tbl[0] = {$urandom(), $urandom()};
        tbl[0][1:0] = SPACE_MEM64;
        bus_wr(REG_ENTRY_BASE, tbl[0][31:0]);
        bus_wr(REG_ENTRY_BASE + 8'h01, tbl[0][63:32]);
        send(0, 20'h12345, 8'h0f, 1'b0);
        go <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        check("drain", 69'h0, expq.size());
        for (k = 0; k < 8; k++) begin
            {tv, tw, tc} <= 3'(k);
            @(posedge i_clk_sys);
            check("tgt", {k[2] & (!k[1] | k[0]), k[2] & k[1] & k[0]},
                {tgt_acc, tgt_now});
            check("dwc", 69'h0, dwc);
        end
        final_report;
    end
endmodule : test_pci_outbound_xlat
